// ==== src/lptm_monitor.sv ====
// line phase timing monitor: phase order, delays, period, sag
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - order check uses rising voltage crossings only
// - A then C then B sets fault bit
// - enabled fault drives interrupt line low
// - writing one to bit clears fault
// - every out-of-order rising crossing sets fault again
// - delays start and stop on rising crossings
// - select 00 measures voltage to current per phase
// - select 01 stores voltage delays AC, BC, AB
// - select 10 stores current delays AC, BC, AB
// - delay is 16-bit count of 256 kHz ticks
// - period measured on selected phase voltage
// - period is 16-bit tick count, once per cycle
// - stored period equals ticks minus one
// - sag below level for half cycles marks phase
// - small voltage amplitude yields no voltage crossing events
// - undervoltage flag set after count; zero invalid
// - clearing undervoltage also clears phase sag flags
module lptm_monitor
    import lptm_pkg::*;
#(
    parameter int RES_W    = 16,
    parameter int LEVEL_W  = 24,
    parameter int SAG_HALFCYCLE_COUNT_W = 8
) (
    input  wire logic                 i_clk,
    input  wire logic                 i_rst,
    input  wire logic [2:0]           i_zxv_rise,
    input  wire logic [2:0]           i_zxv_fall,
    input  wire logic [2:0]           i_zxi_rise,
    input  wire logic [2:0]           i_v_amp_ok,
    input  wire logic [3*LEVEL_W-1:0] i_v_abs,
    input  wire logic [LEVEL_W-1:0]   i_sag_level,
    input  wire logic [SAG_HALFCYCLE_COUNT_W-1:0]  i_sag_halfcycle_count,
    input  wire logic                 i_sag_count_wr,
    input  wire logic [1:0]           i_delay_pair_sel,
    input  wire logic [1:0]           i_line_period_source,
    input  wire logic [FLAG_W-1:0]    i_event_enable_1,
    input  wire logic                 i_flags_wr,
    input  wire logic [FLAG_W-1:0]    i_flags_wdata,
    output logic [RES_W-1:0]          o_delay_result_0,
    output logic [RES_W-1:0]          o_delay_result_1,
    output logic [RES_W-1:0]          o_delay_result_2,
    output logic [RES_W-1:0]          o_line_cycle_length,
    output logic [FLAG_W-1:0]         o_event_flags_1,
    output logic [PHSTAT_W-1:0]       o_phase_event_flags,
    output logic                      o_interrupt_line_1_n
);

    if (RES_W < 2 || RES_W > 32 || LEVEL_W < 1 || SAG_HALFCYCLE_COUNT_W < 1 || SAG_HALFCYCLE_COUNT_W > 16) begin : g_bad_param
        $error("lptm_monitor: unsupported parameter value");
    end

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    // amplitude-qualified voltage crossings
    logic [2:0] rv;
    logic [2:0] fv;
    assign rv = i_zxv_rise & i_v_amp_ok;
    assign fv = i_zxv_fall & i_v_amp_ok;

    // 256 kHz tick: accumulator keeps the average rate exact
    logic [ACC_W-1:0] acc;
    logic [ACC_W-1:0] next_acc;
    logic             tick;
    logic             next_tick;

    always_comb begin
        next_acc  = acc + ACC_STEP;
        next_tick = 1'b0;
        if (next_acc >= ACC_WRAP) begin
            next_acc  = next_acc - ACC_WRAP;
            next_tick = 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            acc  <= '0;
            tick <= 1'b0;
        end else begin
            acc  <= next_acc;
            tick <= next_tick;
        end
    end

    // start/stop crossings; channel 3 is the line period
    logic [3:0] start_ev;
    logic [3:0] stop_ev;
    logic [2:0] pair_ev;

    always_comb begin
        pair_ev = (i_delay_pair_sel == SEL_CURRENTS) ? i_zxi_rise : rv;
        unique case (i_delay_pair_sel)
            SEL_VOLTAGES, SEL_CURRENTS: begin
                start_ev[2:0] = {pair_ev[0], pair_ev[1], pair_ev[0]};
                stop_ev[2:0]  = {pair_ev[1], pair_ev[2], pair_ev[2]};
            end
            default: begin
                start_ev[2:0] = rv;
                stop_ev[2:0]  = i_zxi_rise;
            end
        endcase
        unique case (i_line_period_source)
            SRC_PHASE_B: start_ev[3] = rv[1];
            SRC_PHASE_C: start_ev[3] = rv[2];
            default:     start_ev[3] = rv[0];
        endcase
        stop_ev[3] = start_ev[3];
    end

    logic [4*RES_W-1:0] res_bus;

    for (genvar k = 0; k < 4; k++) begin : g_ch
        logic [RES_W-1:0] cnt;
        logic [RES_W-1:0] res;
        logic             run;
        logic [RES_W-1:0] next_cnt;
        logic [RES_W-1:0] next_res;
        logic             next_run;

        always_comb begin
            next_cnt = cnt;
            next_res = res;
            next_run = run;
            if (tick && cnt != {RES_W{1'b1}}) begin
                next_cnt = cnt + 1'b1;
            end
            if (stop_ev[k] && run) begin
                next_run = 1'b0;
                if (k == 3) begin
                    next_res = (cnt == '0) ? '0 : cnt - 1'b1;
                end else begin
                    next_res = cnt;
                end
            end
            // period start equals its stop, so capture above then restart here
            if (start_ev[k]) begin
                next_cnt = '0;
                next_run = 1'b1;
            end
        end

        always_ff @(posedge i_clk) begin
            if (i_rst) begin
                cnt <= '0;
                res <= '0;
                run <= 1'b0;
            end else begin
                cnt <= next_cnt;
                res <= next_res;
                run <= next_run;
            end
        end

        assign res_bus[k*RES_W +: RES_W] = res;

        property p_saturate;
            (cnt == {RES_W{1'b1}} && !start_ev[k]) |=> cnt == {RES_W{1'b1}};
        endproperty
        a_saturate: assert property (p_saturate) else $error("counter left saturation");
    end

    assign o_delay_result_0    = res_bus[0*RES_W +: RES_W];
    assign o_delay_result_1    = res_bus[1*RES_W +: RES_W];
    assign o_delay_result_2    = res_bus[2*RES_W +: RES_W];
    assign o_line_cycle_length = res_bus[3*RES_W +: RES_W];

    // sag: per phase count of whole half cycles spent below level
    logic [2:0] sag_hit;

    for (genvar p = 0; p < 3; p++) begin : g_sag
        logic                below;
        logic [SAG_HALFCYCLE_COUNT_W-1:0] hc_cnt;
        logic                next_below;
        logic [SAG_HALFCYCLE_COUNT_W-1:0] next_hc_cnt;
        logic                under;
        logic                full;
        logic                hit;

        assign under = i_v_abs[p*LEVEL_W +: LEVEL_W] < i_sag_level;
        assign full  = below && under;
        // one driver per bit keeps the shared vector out of every comb process
        assign sag_hit[p] = hit;

        always_comb begin
            next_below  = below && under;
            next_hc_cnt = hc_cnt;
            hit         = 1'b0;
            if (rv[p] || fv[p]) begin
                next_below  = 1'b1;
                next_hc_cnt = full ? hc_cnt + 1'b1 : '0;
                // a zero count never matches, so it never fires
                if (full && i_sag_halfcycle_count != '0 && next_hc_cnt == i_sag_halfcycle_count) begin
                    hit         = 1'b1;
                    next_hc_cnt = '0;
                end
            end
            if (i_sag_count_wr) begin
                next_hc_cnt = '0;
            end
        end

        always_ff @(posedge i_clk) begin
            if (i_rst) begin
                below  <= 1'b0;
                hc_cnt <= '0;
            end else begin
                below  <= next_below;
                hc_cnt <= next_hc_cnt;
            end
        end
    end

    // phase order checker
    lptm_seen_e seen;
    lptm_seen_e next_seen;
    logic [2:0] rv_first;
    logic [2:0] expect_oh;
    logic       seq_fault;

    assign rv_first = rv & (~rv + 3'h1);

    always_comb begin
        next_seen = seen;
        expect_oh = 3'h0;
        unique case (seen)
            LPTM_SEEN_NONE: expect_oh = 3'h0;
            LPTM_SEEN_A:    expect_oh = 3'h2;
            LPTM_SEEN_B:    expect_oh = 3'h4;
            LPTM_SEEN_C:    expect_oh = 3'h1;
            default:        expect_oh = 3'h0;
        endcase
        // current channels and falling edges never reach this checker
        seq_fault = (rv != 3'h0) && (seen != LPTM_SEEN_NONE) && (rv_first != expect_oh);
        if (rv_first == 3'h1) next_seen = LPTM_SEEN_A;
        if (rv_first == 3'h2) next_seen = LPTM_SEEN_B;
        if (rv_first == 3'h4) next_seen = LPTM_SEEN_C;
    end

    // flags: a set in the clear cycle wins
    logic       fault_flag;
    logic       uv_flag;
    logic [2:0] sag_phase;
    logic       next_fault_flag;
    logic       next_uv_flag;
    logic [2:0] next_sag_phase;
    logic       clr_fault;
    logic       clr_uv;

    assign clr_fault = i_flags_wr && i_flags_wdata[PHASE_ORDER_BIT];
    assign clr_uv    = i_flags_wr && i_flags_wdata[UNDERVOLT_BIT];

    always_comb begin
        next_fault_flag = seq_fault || (fault_flag && !clr_fault);
        next_uv_flag    = (sag_hit != 3'h0) || (uv_flag && !clr_uv);
        next_sag_phase  = clr_uv ? 3'h0 : sag_phase;
        if (sag_hit != 3'h0) begin
            next_sag_phase = sag_hit;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            seen       <= LPTM_SEEN_NONE;
            fault_flag <= 1'b0;
            uv_flag    <= 1'b0;
            sag_phase  <= 3'h0;
        end else begin
            seen       <= next_seen;
            fault_flag <= next_fault_flag;
            uv_flag    <= next_uv_flag;
            sag_phase  <= next_sag_phase;
        end
    end

    assign o_event_flags_1 = (FLAG_W'(fault_flag) << PHASE_ORDER_BIT) | (FLAG_W'(uv_flag) << UNDERVOLT_BIT);
    assign o_phase_event_flags = PHSTAT_W'(sag_phase) << SAG_PHASE_LSB;
    assign o_interrupt_line_1_n = ~|(o_event_flags_1 & i_event_enable_1);

    // checks
    sequence s_a_then_c;
        (seen == LPTM_SEEN_A) && (rv == 3'h4);
    endsequence
    sequence s_c_then_b;
        (seen == LPTM_SEEN_C) && (rv == 3'h2);
    endsequence

    property p_order_fault;
        s_a_then_c |=> fault_flag;
    endproperty
    a_order_fault: assert property (p_order_fault) else $error("A then C did not flag");

    property p_order_again;
        s_c_then_b |=> fault_flag;
    endproperty
    a_order_again: assert property (p_order_again) else $error("reverse crossing not flagged");

    property p_irq_low;
        (seq_fault && i_event_enable_1[PHASE_ORDER_BIT]) |=> !o_interrupt_line_1_n;
    endproperty
    a_irq_low: assert property (p_irq_low) else $error("interrupt not driven low");

    property p_fault_clear;
        (clr_fault && !seq_fault) |=> !fault_flag;
    endproperty
    a_fault_clear: assert property (p_fault_clear) else $error("fault flag not cleared");

    property p_fault_hold;
        (fault_flag && !clr_fault) |=> fault_flag;
    endproperty
    a_fault_hold: assert property (p_fault_hold) else $error("fault flag lost");

    property p_no_voltage_edge;
        (rv == 3'h0) |=> $stable(seen);
    endproperty
    a_no_voltage_edge: assert property (p_no_voltage_edge) else $error("order state moved without edge");

    property p_small_amp;
        (i_v_amp_ok == 3'h0) |=> (seen == $past(seen)) && !$rose(fault_flag);
    endproperty
    a_small_amp: assert property (p_small_amp) else $error("small amplitude made an event");

    property p_delay_capture;
        (g_ch[0].run && stop_ev[0]) |=> o_delay_result_0 == $past(g_ch[0].cnt);
    endproperty
    a_delay_capture: assert property (p_delay_capture) else $error("delay not captured");

    property p_period_minus_one;
        (g_ch[3].run && stop_ev[3] && g_ch[3].cnt != '0) |=>
            o_line_cycle_length == RES_W'($past(g_ch[3].cnt) - 1'b1);
    endproperty
    a_period_minus_one: assert property (p_period_minus_one) else $error("period not ticks minus one");

    property p_tick_spacing;
        tick |=> !tick [*8];
    endproperty
    a_tick_spacing: assert property (p_tick_spacing) else $error("ticks too close");

    property p_sag_set;
        (sag_hit != 3'h0) |=> uv_flag && (sag_phase == $past(sag_hit));
    endproperty
    a_sag_set: assert property (p_sag_set) else $error("sag event not recorded");

    property p_sag_clear;
        (clr_uv && sag_hit == 3'h0) |=> !uv_flag && (o_phase_event_flags == '0);
    endproperty
    a_sag_clear: assert property (p_sag_clear) else $error("sag flags not cleared");

endmodule

`default_nettype wire

// ==== src/lptm_pkg.sv ====
// constants for the line phase timing monitor
package lptm_pkg;
    // clock and measurement tick rates, kHz; the tick is a fractional divide
    localparam int unsigned CLK_KHZ  = 100000;
    localparam int unsigned TICK_KHZ = 256;
    localparam int          ACC_W    = 17;
    localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(TICK_KHZ);
    localparam logic [ACC_W-1:0] ACC_WRAP = ACC_W'(CLK_KHZ);

    localparam int FLAG_W          = 32;
    localparam int PHSTAT_W        = 16;
    localparam int PHASE_ORDER_BIT = 19;
    localparam int UNDERVOLT_BIT   = 16;
    localparam int SAG_PHASE_LSB   = 12;

    // delay_pair_sel encodings
    localparam logic [1:0] SEL_SAME_PHASE = 2'h0;
    localparam logic [1:0] SEL_VOLTAGES   = 2'h1;
    localparam logic [1:0] SEL_CURRENTS   = 2'h2;
    // line_period_source encodings
    localparam logic [1:0] SRC_PHASE_B = 2'h1;
    localparam logic [1:0] SRC_PHASE_C = 2'h2;

    // last rising voltage crossing seen
    typedef enum logic [3:0] {
        LPTM_SEEN_NONE = 4'b0001,
        LPTM_SEEN_A    = 4'b0010,
        LPTM_SEEN_B    = 4'b0100,
        LPTM_SEEN_C    = 4'b1000
    } lptm_seen_e;
endpackage

// ==== verification/tb_lptm_monitor.sv ====
// self-checking bench for the line phase timing monitor
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, (g), (e)); end end

module tb_lptm_monitor;
    import lptm_pkg::*;

    typedef struct packed {
        logic       kind;
        logic [1:0] sel;
        logic       sta_i;
        logic       stp_i;
        logic [1:0] sta;
        logic [1:0] stp;
        logic [1:0] idx;
        int         cyc;
    } lptm_row_s;

    logic        clk = 1'b0;
    logic        rst;
    logic [2:0]  zv_r, zv_f, zi_r, amp;
    logic [71:0] vabs;
    logic [23:0] lvl;
    logic [7:0]  cnt;
    logic        cnt_wr, fwr;
    logic [1:0]  dsel, psrc;
    logic [31:0] en, fwd, flags;
    logic [15:0] r0, r1, r2, per, phf, got, lo, hi;
    logic        irq_n;
    logic [1:0]  sat_r0;
    int          mismatches = 0;
    int          comparisons = 0;
    int          ticks;
    lptm_row_s   r;
    // kind 0 = delay (sel = pair select), kind 1 = period (sel = source)
    lptm_row_s   rows [15] = '{
        '{0, 2'h0, 0, 1, 0, 0, 0, 1000}, '{0, 2'h0, 0, 1, 1, 1, 1, 2345},
        '{0, 2'h0, 0, 1, 2, 2, 2, 777},  '{0, 2'h3, 0, 1, 0, 0, 0, 1500},
        '{0, 2'h1, 0, 0, 0, 2, 0, 1200}, '{0, 2'h1, 0, 0, 1, 2, 1, 3000},
        '{0, 2'h1, 0, 0, 0, 1, 2, 2000}, '{0, 2'h2, 1, 1, 0, 2, 0, 1800},
        '{0, 2'h2, 1, 1, 1, 2, 1, 900},  '{0, 2'h2, 1, 1, 0, 1, 2, 2600},
        '{1, 2'h0, 0, 0, 0, 0, 3, 5000}, '{1, 2'h1, 0, 0, 1, 1, 3, 4100},
        '{1, 2'h2, 0, 0, 2, 2, 3, 3333}, '{1, 2'h3, 0, 0, 0, 0, 3, 2500},
        '{0, 2'h0, 0, 1, 1, 1, 1, 60}
    };

    lptm_monitor uut (
        .i_clk                 (clk),
        .i_rst                 (rst),
        .i_zxv_rise            (zv_r),
        .i_zxv_fall            (zv_f),
        .i_zxi_rise            (zi_r),
        .i_v_amp_ok            (amp),
        .i_v_abs               (vabs),
        .i_sag_level           (lvl),
        .i_sag_halfcycle_count (cnt),
        .i_sag_count_wr        (cnt_wr),
        .i_delay_pair_sel      (dsel),
        .i_line_period_source  (psrc),
        .i_event_enable_1      (en),
        .i_flags_wr            (fwr),
        .i_flags_wdata         (fwd),
        .o_delay_result_0      (r0),
        .o_delay_result_1      (r1),
        .o_delay_result_2      (r2),
        .o_line_cycle_length   (per),
        .o_event_flags_1       (flags),
        .o_phase_event_flags   (phf),
        .o_interrupt_line_1_n  (irq_n)
    );

    // narrow copy: its counters reach saturation within a short run
    lptm_monitor #(
        .RES_W (2)
    ) uut_sat (
        .i_clk                 (clk),
        .i_rst                 (rst),
        .i_zxv_rise            (zv_r),
        .i_zxv_fall            (zv_f),
        .i_zxi_rise            (zi_r),
        .i_v_amp_ok            (amp),
        .i_v_abs               (vabs),
        .i_sag_level           (lvl),
        .i_sag_halfcycle_count (cnt),
        .i_sag_count_wr        (cnt_wr),
        .i_delay_pair_sel      (dsel),
        .i_line_period_source  (psrc),
        .i_event_enable_1      (en),
        .i_flags_wr            (fwr),
        .i_flags_wdata         (fwd),
        .o_delay_result_0      (sat_r0),
        .o_delay_result_1      (),
        .o_delay_result_2      (),
        .o_line_cycle_length   (),
        .o_event_flags_1       (),
        .o_phase_event_flags   (),
        .o_interrupt_line_1_n  ()
    );

    always #5 clk = ~clk;

    function automatic logic [2:0] oh(input logic [1:0] ph);
        return 3'h1 << ph;
    endfunction

    function automatic logic [15:0] res(input logic [1:0] i);
        case (i)
            2'h0: return r0;
            2'h1: return r1;
            2'h2: return r2;
            default: return per;
        endcase
    endfunction

    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask

    // one-cycle event pulses, sampled at the rising edge in between
    task automatic pulse(input logic [2:0] vr, input logic [2:0] vf, input logic [2:0] ir);
        @(negedge clk);
        zv_r = vr;
        zv_f = vf;
        zi_r = ir;
        @(negedge clk);
        zv_r = 3'h0;
        zv_f = 3'h0;
        zi_r = 3'h0;
    endtask

    // leading idle keeps a clear away from the edge that lands an event
    task automatic wflag(input logic [31:0] d);
        idle(2);
        fwr = 1'b1;
        fwd = d;
        @(negedge clk);
        fwr = 1'b0;
        idle(1);
    endtask

    task automatic complete_run;
        if (mismatches == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        #600_000;
        mismatches++;
        complete_run();
    end

    initial begin
        rst = 1'b1; zv_r = 3'h0; zv_f = 3'h0; zi_r = 3'h0; amp = 3'h7;
        vabs = {3{24'h10_0000}}; lvl = 24'h00_1000; cnt = 8'h00; cnt_wr = 1'b0;
        dsel = 2'h0; psrc = 2'h0; en = 32'h0000_0000; fwr = 1'b0; fwd = 32'h0000_0000;
        idle(20);
        rst = 1'b0;
        idle(1);
        `CHK({r0, r1, r2, per, phf, flags, irq_n}, 113'h1)
        for (int k = 0; k < 15; k++) begin
            r = rows[k];
            dsel = r.kind ? 2'h0 : r.sel;
            psrc = r.sel;
            idle(4);
            pulse(r.sta_i ? 3'h0 : oh(r.sta), 3'h0, r.sta_i ? oh(r.sta) : 3'h0);
            idle(r.cyc - 1);
            pulse(r.stp_i ? 3'h0 : oh(r.stp), 3'h0, r.stp_i ? oh(r.stp) : 3'h0);
            idle(1);
            // tick phase against the start is free, so allow one tick either way
            ticks = r.cyc * TICK_KHZ / CLK_KHZ - int'(r.kind);
            lo = (ticks > 0) ? 16'(ticks - 1) : 16'h0000;
            hi = 16'(ticks + 1);
            got = res(r.idx);
            `CHK((got >= lo) && (got <= hi), 1'b1)
        end
        // long same-phase delay: wide copy counts, narrow copy saturates
        pulse(3'h1, 3'h0, 3'h0);
        idle(2000);
        pulse(3'h0, 3'h0, 3'h1);
        idle(1);
        `CHK((r0 >= 16'h0004) && (r0 <= 16'h0006), 1'b1)
        `CHK(sat_r0, 2'h3)
        pulse(3'h1, 3'h0, 3'h0);
        wflag(32'hFFFF_FFFF);
        pulse(3'h2, 3'h0, 3'h0);
        pulse(3'h4, 3'h0, 3'h0);
        pulse(3'h1, 3'h0, 3'h0);
        idle(1);
        `CHK(flags[PHASE_ORDER_BIT], 1'b0)
        pulse(3'h4, 3'h0, 3'h0);
        idle(1);
        `CHK({flags[PHASE_ORDER_BIT], irq_n}, 2'b11)
        en = 32'h0008_0000;
        idle(1);
        `CHK(irq_n, 1'b0)
        wflag(32'h0000_0000);
        `CHK(flags[PHASE_ORDER_BIT], 1'b1)
        wflag(32'h0008_0000);
        `CHK({flags[PHASE_ORDER_BIT], irq_n}, 2'b01)
        pulse(3'h2, 3'h0, 3'h0);
        idle(1);
        `CHK(flags[PHASE_ORDER_BIT], 1'b1)
        wflag(32'h0008_0000);
        pulse(3'h0, 3'h1, 3'h0);
        pulse(3'h0, 3'h0, 3'h1);
        amp = 3'h0;
        pulse(3'h1, 3'h0, 3'h0);
        amp = 3'h7;
        pulse(3'h4, 3'h0, 3'h0);
        idle(1);
        `CHK({flags[PHASE_ORDER_BIT], irq_n}, 2'b01)
        en = 32'h0001_0000;
        vabs = {24'h10_0000, 24'h00_0100, 24'h10_0000};
        for (int c = 0; c < 2; c++) begin
            cnt = c ? 8'h02 : 8'h00;
            @(negedge clk);
            cnt_wr = 1'b1;
            @(negedge clk);
            cnt_wr = 1'b0;
            for (int b = 0; b < 4; b++) begin
                idle(20);
                pulse(b[0] ? 3'h0 : 3'h2, b[0] ? 3'h2 : 3'h0, 3'h0);
                idle(1);
                if (c == 0 || b == 0)
                    `CHK(flags[UNDERVOLT_BIT], 1'b0)
            end
        end
        `CHK({flags[UNDERVOLT_BIT], phf[14:12], irq_n}, 5'b1_0100)
        wflag(32'h0001_0000);
        `CHK({flags[UNDERVOLT_BIT], phf, irq_n}, 18'h0_0001)
        // out-of-order crossing in the clear cycle: the set wins
        @(negedge clk);
        zv_r = 3'h1;
        fwr  = 1'b1;
        fwd  = 32'h0008_0000;
        @(negedge clk);
        zv_r = 3'h0;
        fwr  = 1'b0;
        idle(1);
        `CHK(flags[PHASE_ORDER_BIT], 1'b1)
        // a second reset in mid-run must clear results left from the table
        @(negedge clk);
        rst = 1'b1;
        idle(2);
        rst = 1'b0;
        idle(1);
        `CHK({r0, r1, r2, per, phf, flags, irq_n}, 113'h1)
        complete_run();
    end
endmodule
`default_nettype wire
